// ### logic/spi_frame_pkg.sv
/*
 * Shared constants of the serial frame slave: frame geometry, bit counter
 * width, buffer depth, state codes and the response sent after reset.
 * Assumes nothing of its surroundings; both design files import it.
 */
package spi_frame_pkg;

    localparam int FRAME_W = 16;
    localparam int CNT_W = 10;
    localparam logic [9:0] MIN_BITS = 10'h010;
    localparam int GRAIN_LSB = 3;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_IDX_W = 1;

    // arbitrary marker pattern, not tied to any part
    localparam logic [15:0] SPECIAL_FRAME = 16'hA5C3;
    localparam logic [15:0] FRAME_ZERO = 16'h0000;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;
    localparam logic [9:0] CNT_MAX = 10'h3FF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } link_state_t;

endpackage

// ### logic/hold_buffer.sv
/*
 * Two-entry word buffer with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset; the filling side
 * holds its word and valid until ready is seen.
 */
`timescale 1ns/1ps

module hold_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2,
    parameter int IDX_W = 1
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    import spi_frame_pkg::*;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [IDX_W-1:0] wr_q;
    logic [IDX_W-1:0] rd_q;
    logic [IDX_W:0] fill_q;
    logic push;
    logic pop;

    function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx);
        next_idx = (int'(idx) == DEPTH - 1) ? '0 : IDX_W'(int'(idx) + 1);
    endfunction

    assign IN_READY = (int'(fill_q) < DEPTH);
    assign OUT_VALID = (fill_q != '0);
    assign OUT_DATA = mem_q[rd_q];
    assign push = IN_VALID && IN_READY;
    assign pop = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push) begin
            mem_q[wr_q] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_q <= '0;
            rd_q <= '0;
            fill_q <= '0;
        end else begin
            if (push) begin
                wr_q <= next_idx(wr_q);
            end
            if (pop) begin
                rd_q <= next_idx(rd_q);
            end
            if (push && !pop) begin
                fill_q <= fill_q + 1'b1;
            end else if (pop && !push) begin
                fill_q <= fill_q - 1'b1;
            end
        end
    end

endmodule

// ### logic/spi_frame_slave.sv
/*
 * Serial frame slave: samples chip select, serial clock and serial input
 * with the system clock, shifts frames MSB first, checks the bit count and
 * hands accepted frames to a two-entry buffer.
 * Assumes CLK well above the link clock (160 ns link period in the bench)
 * and a downstream consumer of FRAME_DATA on the same clock.
 */
`timescale 1ns/1ps

module spi_frame_slave (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CSN,
    input wire logic SCLK,
    input wire logic SI,
    input wire logic SLEEP,
    input wire logic SOFT_RST,
    input wire logic [spi_frame_pkg::FRAME_W-1:0] RESP_DATA,
    output logic SO,
    output logic SO_OE,
    output logic TRANSMISSION_ERROR_FLAG,
    output logic FRAME_VALID,
    input wire logic FRAME_READY,
    output logic [spi_frame_pkg::FRAME_W-1:0] FRAME_DATA
);
    import spi_frame_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and glitch filter

    logic [2:0] csn_s_q;
    logic [2:0] sclk_s_q;
    logic [2:0] si_s_q;
    logic csn_f_q;
    logic sclk_f_q;
    logic si_f_q;
    logic csn_fall;
    logic csn_rise;
    logic sclk_fall;
    logic sclk_rise;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            csn_s_q <= 3'h7;
            sclk_s_q <= 3'h0;
            si_s_q <= 3'h0;
        end else begin
            csn_s_q <= {csn_s_q[1:0], CSN};
            sclk_s_q <= {sclk_s_q[1:0], SCLK};
            si_s_q <= {si_s_q[1:0], SI};
        end
    end

    // a level counts only once stages two and three agree
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            csn_f_q <= 1'b1;
            sclk_f_q <= 1'b0;
            si_f_q <= 1'b0;
        end else begin
            if (csn_s_q[1] == csn_s_q[2]) begin
                csn_f_q <= csn_s_q[2];
            end
            if (sclk_s_q[1] == sclk_s_q[2]) begin
                sclk_f_q <= sclk_s_q[2];
            end
            if (si_s_q[1] == si_s_q[2]) begin
                si_f_q <= si_s_q[2];
            end
        end
    end

    assign csn_fall = (csn_s_q[1] == csn_s_q[2]) && !csn_s_q[2] && csn_f_q;
    assign csn_rise = (csn_s_q[1] == csn_s_q[2]) && csn_s_q[2] && !csn_f_q;
    assign sclk_fall = (sclk_s_q[1] == sclk_s_q[2]) && !sclk_s_q[2] && sclk_f_q;
    assign sclk_rise = (sclk_s_q[1] == sclk_s_q[2]) && sclk_s_q[2] && !sclk_f_q;

    ////////////////////////////////////////////////////////////////////////
    // access state and bit counter

    link_state_t state_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic sclk_bad_q;
    logic first_q;
    logic transmission_error_flag_q;
    logic [FRAME_W-1:0] sh_q;
    logic so_q;
    logic so_oe_q;
    logic pend_q;
    logic [FRAME_W-1:0] pend_data_q;
    logic buf_ready;
    logic in_shift;
    logic frame_ok;

    function automatic logic len_ok(input logic [CNT_W-1:0] cnt);
        len_ok = (cnt >= MIN_BITS) && (cnt[GRAIN_LSB-1:0] == '0) && (cnt != CNT_MAX);
    endfunction

    assign in_shift = (state_q == ST_SHIFT);
    // sclk high at a chip select edge rejects the access
    assign frame_ok = len_ok(bit_cnt_q) && !sclk_bad_q && !sclk_f_q;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (csn_fall && !SLEEP) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (csn_rise) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // counter saturates; a saturated count never passes the length check
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bit_cnt_q <= CNT_ZERO;
            sclk_bad_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            if (csn_fall && !SLEEP) begin
                bit_cnt_q <= CNT_ZERO;
                sclk_bad_q <= sclk_f_q;
            end
        end else if (sclk_fall && bit_cnt_q != CNT_MAX) begin
            bit_cnt_q <= bit_cnt_q + CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register and serial output

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sh_q <= FRAME_ZERO;
        end else if (state_q == ST_IDLE) begin
            if (csn_fall && !SLEEP) begin
                // answer to the previous access, never to this one
                sh_q <= first_q ? SPECIAL_FRAME : RESP_DATA;
            end
        end else if (sclk_fall) begin
            sh_q <= {sh_q[FRAME_W-2:0], si_f_q};
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            so_oe_q <= 1'b0;
            if (csn_fall && !SLEEP) begin
                so_oe_q <= 1'b1;
                so_q <= transmission_error_flag_q | si_f_q;
            end
        end else if (csn_rise) begin
            so_oe_q <= 1'b0;
        end else if (sclk_rise) begin
            so_q <= sh_q[FRAME_W-1];
        end else if (bit_cnt_q == CNT_ZERO && !sclk_f_q) begin
            // lets an error ripple down a daisy chain before any clock
            // count moves only on falls, so the high sclk marks the first rise
            so_q <= transmission_error_flag_q | si_f_q;
        end
    end

    assign SO = so_q;
    assign SO_OE = so_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // end of access: length check, error flag, commit

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            first_q <= 1'b1;
        end else if (SOFT_RST) begin
            first_q <= 1'b1;
        end else if (state_q == ST_IDLE && csn_fall && !SLEEP) begin
            first_q <= 1'b0;
        end
    end

    // a frame still waiting for the buffer when the next one ends is an overrun
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            transmission_error_flag_q <= 1'b0;
        end else if (in_shift && csn_rise) begin
            transmission_error_flag_q <= !frame_ok || pend_q;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_q <= 1'b0;
            pend_data_q <= FRAME_ZERO;
        end else if (in_shift && csn_rise && frame_ok && !pend_q) begin
            pend_q <= 1'b1;
            pend_data_q <= sh_q;
        end else if (pend_q && buf_ready) begin
            pend_q <= 1'b0;
        end
    end

    assign TRANSMISSION_ERROR_FLAG = transmission_error_flag_q;

    hold_buffer #(
        .WIDTH(FRAME_W),
        .DEPTH(BUF_DEPTH),
        .IDX_W(BUF_IDX_W)
    ) u_frame_buf (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .IN_VALID(pend_q),
        .IN_READY(buf_ready),
        .IN_DATA(pend_data_q),
        .OUT_VALID(FRAME_VALID),
        .OUT_READY(FRAME_READY),
        .OUT_DATA(FRAME_DATA)
    );

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_idle_released;
        @(posedge CLK) disable iff (!ARST_N)
        (state_q == ST_IDLE && !csn_fall) |=> !SO_OE;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("SO driven outside access");

    property p_start_enables;
        @(posedge CLK) disable iff (!ARST_N)
        (state_q == ST_IDLE && csn_fall && !SLEEP) |=> SO_OE && in_shift && bit_cnt_q == CNT_ZERO;
    endproperty
    a_start_enables: assert property (p_start_enables) else $error("access did not start");

    property p_sleep_blocks;
        @(posedge CLK) disable iff (!ARST_N)
        (state_q == ST_IDLE && csn_fall && SLEEP) |=> !SO_OE && state_q == ST_IDLE;
    endproperty
    a_sleep_blocks: assert property (p_sleep_blocks) else $error("transfer started in sleep");

    property p_first_bit;
        @(posedge CLK) disable iff (!ARST_N)
        (state_q == ST_IDLE && csn_fall && !SLEEP) |=> SO == ($past(transmission_error_flag_q) | $past(si_f_q));
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("SO not error OR SI at start");

    property p_out_on_rise;
        @(posedge CLK) disable iff (!ARST_N)
        (in_shift && sclk_rise && !csn_rise) |=> SO == $past(sh_q[FRAME_W-1]);
    endproperty
    a_out_on_rise: assert property (p_out_on_rise) else $error("SO not MSB after rise");

    property p_in_on_fall;
        @(posedge CLK) disable iff (!ARST_N)
        (in_shift && sclk_fall) |=> sh_q[0] == $past(si_f_q) && sh_q[FRAME_W-1] == $past(sh_q[FRAME_W-2]);
    endproperty
    a_in_on_fall: assert property (p_in_on_fall) else $error("SI not shifted on fall");

    property p_out_holds;
        @(posedge CLK) disable iff (!ARST_N)
        (in_shift && !sclk_rise && !csn_rise && !(bit_cnt_q == CNT_ZERO && !sclk_f_q)) |=> $stable(SO);
    endproperty
    a_out_holds: assert property (p_out_holds) else $error("SO moved between rises");

    property p_bad_len;
        @(posedge CLK) disable iff (!ARST_N)
        (in_shift && csn_rise && !len_ok(bit_cnt_q)) |=> TRANSMISSION_ERROR_FLAG && !$rose(pend_q);
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("bad length not flagged");

    property p_commit;
        @(posedge CLK) disable iff (!ARST_N)
        (in_shift && csn_rise && frame_ok && !pend_q) |=>
            pend_q && !TRANSMISSION_ERROR_FLAG && pend_data_q == $past(sh_q);
    endproperty
    a_commit: assert property (p_commit) else $error("valid frame not committed");

    property p_special;
        @(posedge CLK) disable iff (!ARST_N)
        (state_q == ST_IDLE && csn_fall && !SLEEP && first_q && !SOFT_RST) |=> sh_q == SPECIAL_FRAME;
    endproperty
    a_special: assert property (p_special) else $error("first answer not special");

    property p_answer;
        @(posedge CLK) disable iff (!ARST_N)
        (state_q == ST_IDLE && csn_fall && !SLEEP && !first_q) |=> sh_q == $past(RESP_DATA);
    endproperty
    a_answer: assert property (p_answer) else $error("response not loaded at start");

    c_commit: cover property (@(posedge CLK) disable iff (!ARST_N) in_shift && csn_rise && frame_ok);
    c_bad: cover property (@(posedge CLK) disable iff (!ARST_N) in_shift && csn_rise && !frame_ok);
    c_sleep: cover property (@(posedge CLK) disable iff (!ARST_N) csn_fall && SLEEP);
    c_chain: cover property (@(posedge CLK) disable iff (!ARST_N)
        in_shift && csn_rise && frame_ok && bit_cnt_q == 10'h018);

endmodule

// ### testbench/spi_master_model.sv
/*
 * Serial master model: chip select, serial clock and data in, reads data out.
 * Assumes clk is the block clock; the link half period is 4 clk (80 ns).
 */
`timescale 1ns/1ps

module spi_master_model (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output logic csn,
    output logic sclk,
    output logic si
);
    initial begin
        csn = 1'h1;
        sclk = 1'h0;
        si = 1'h0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // sclk kept low at both chip select edges
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
                        output logic pre, output logic oe_any);
        rx = 32'h0000_0000;
        si = tx[nbits-1];
        csn = 1'h0;
        step(12);
        pre = so;
        oe_any = so_oe;
        for (int i = nbits - 1; i >= 0; i--) begin
            si = tx[i];
            sclk = 1'h1;
            step(4);
            sclk = 1'h0;
            step(4);
            rx = {rx[30:0], so};
            oe_any |= so_oe;
        end
        // lag from the last fall to the select rise above 200 ns
        step(8);
        csn = 1'h1;
        si = 1'h0; // released line sits at its pull-down
        // deselect gap above 250 ns before any next access
        step(16);
    endtask

    // activity while deselected
    task automatic wiggle(output logic oe_any);
        oe_any = 1'h0;
        for (int i = 0; i < 8; i++) begin
            si = ~si;
            sclk = ~sclk;
            step(4);
            oe_any |= so_oe;
        end
    endtask
endmodule

// ### testbench/tb.sv
/*
 * Self-checking bench of the serial frame slave with a master model.
 * Assumes the design package and both design files are compiled first.
 */
`timescale 1ns/1ps

module tb;
    import spi_frame_pkg::*;

    logic clk;
    logic arst_n;
    logic sleep;
    logic soft_rst;
    logic frame_ready;
    logic [FRAME_W-1:0] resp_data = 16'h3C5A;
    wire csn;
    wire sclk;
    wire si;
    logic so;
    logic so_oe;
    logic transmission_error_flag;
    logic frame_valid;
    logic [FRAME_W-1:0] frame_data;
    logic so_last = 1'h0;
    // undriven pin shows the inverse of its last value
    wire so_pin = so_oe ? so : ~so_last;
    int error_cnt = 0;
    int checks = 0;
    logic exp_err = 1'h0;
    logic [FRAME_W-1:0] exp_ans = SPECIAL_FRAME;

    always @(posedge clk) if (so_oe) so_last <= so;

    spi_frame_slave dut (.CLK(clk), .ARST_N(arst_n), .CSN(csn), .SCLK(sclk), .SI(si), .SLEEP(sleep),
        .SOFT_RST(soft_rst), .RESP_DATA(resp_data), .SO(so), .SO_OE(so_oe),
        .TRANSMISSION_ERROR_FLAG(transmission_error_flag),
        .FRAME_VALID(frame_valid), .FRAME_READY(frame_ready), .FRAME_DATA(frame_data));

    spi_master_model m (.clk(clk), .so(so_pin), .so_oe(so_oe), .csn(csn), .sclk(sclk), .si(si));

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one access; ovr marks a frame refused for lack of buffer room
    task automatic access(input logic [31:0] tx, input int n, input logic ovr);
        logic [31:0] rx;
        logic pre;
        logic oe;
        logic [47:0] s;
        s = {exp_ans, tx << (32 - n)};
        m.xfer(tx, n, rx, pre, oe);
        cmp_bit(pre, exp_err | tx[n-1], "so before first clock");
        cmp_bit(oe, 1'h1, "so enabled");
        cmp_word(rx, 32'(s >> (48 - n)), "so stream");
        exp_err = ovr | !(n >= 16 && n % 8 == 0);
        exp_ans = resp_data;
        cmp_bit(transmission_error_flag, exp_err, "error flag");
    endtask

    task automatic pop(input logic [FRAME_W-1:0] exp);
        cmp_bit(frame_valid, 1'h1, "frame waiting");
        cmp_word(32'(frame_data), 32'(exp), "frame word");
        frame_ready = 1'h1;
        step(1);
        frame_ready = 1'h0;
        step(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_first;
        cmp_bit(so_oe, 1'h0, "so released after reset");
        access(32'h0000_8123, 16, 1'h0);
        pop(16'h8123);
    endtask

    task automatic t_counts;
        int ns[7] = '{24, 32, 15, 17, 8, 20, 16};
        foreach (ns[i]) begin
            access(32'hC3A5_6E19, ns[i], 1'h0);
            if (!exp_err)
                pop(16'h6E19);
            else
                cmp_bit(frame_valid, 1'h0, "refused frame kept out");
        end
    endtask

    task automatic t_sleep;
        logic [31:0] rx;
        logic pre;
        logic oe;
        sleep = 1'h1;
        m.xfer(32'h0000_FFFF, 16, rx, pre, oe);
        cmp_bit(oe, 1'h0, "so kept off in sleep");
        cmp_bit(frame_valid, 1'h0, "no transfer in sleep");
        sleep = 1'h0;
    endtask

    task automatic t_idle;
        logic oe;
        m.wiggle(oe);
        cmp_bit(oe, 1'h0, "so released while deselected");
        cmp_bit(frame_valid, 1'h0, "no frame while deselected");
        cmp_bit(transmission_error_flag, exp_err, "flag kept while deselected");
    endtask

    task automatic t_buffer;
        access(32'h0000_1111, 16, 1'h0);
        access(32'h0000_2222, 16, 1'h0);
        access(32'h0000_3333, 16, 1'h0); // third waits for a slot
        access(32'h0000_4444, 16, 1'h1); // overrun refused
        pop(16'h1111);
        pop(16'h2222);
        pop(16'h3333);
        cmp_bit(frame_valid, 1'h0, "buffer drained");
    endtask

    task automatic t_soft;
        soft_rst = 1'h1;
        step(1);
        soft_rst = 1'h0;
        exp_ans = SPECIAL_FRAME;
        access(32'h0000_5AA5, 16, 1'h0);
        pop(16'h5AA5);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: run hung", $time);
        finish_test();
    end

    initial begin
        arst_n = 1'h0;
        sleep = 1'h0;
        soft_rst = 1'h0;
        frame_ready = 1'h0;
        step(12);
        arst_n = 1'h1;
        step(2);
        t_first();
        t_counts();
        t_sleep();
        t_idle();
        t_buffer();
        t_soft();
        finish_test();
    end
endmodule
